//--- verilog/dual_timer_event_counter.sv
// two 16-bit timer/event counter channels with shared mode register
`default_nettype none
module dual_timer_event_counter (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// processor core register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// run bits from the core
	input wire logic chan0_run,
	input wire logic chan1_run,
	// external pins
	input wire logic count_input_a,
	input wire logic count_input_b,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	// overflow flags toward the interrupt logic
	input wire logic [1:0] overflow_clear,
	output logic [1:0] overflow_flag
);
	typedef struct packed {
		logic [7:0] mode_ctrl;
		logic [7:0] low0;
		logic [7:0] high0;
		logic [7:0] low1;
		logic [7:0] high1;
		logic [1:0] ovf;
		logic [7:0] rdata;
	} state_t;

	state_t s_reg;
	state_t s_next;

	timer_link_if #(.CHANNELS(timer_pkg::CHANNELS)) lk ();

	machine_cycle_gen #(
		.OSC_PER_MC(timer_pkg::OSC_PER_MACHINE_CYCLE)
	) u_gen (
		.clk(clk),
		.srst(srst),
		.lk(lk.gen)
	);

	count_sampler #(
		.CHANNELS(timer_pkg::CHANNELS)
	) u_samp (
		.clk(clk),
		.srst(srst),
		.count_pins({count_input_b, count_input_a}),
		.gate_pins({ext_irq_pin_b, ext_irq_pin_a}),
		.lk(lk.samp)
	);

	// one count step; result is {carry out, high byte, low byte}
	function automatic logic [16:0] step(input timer_pkg::op_mode_t mode,
			input logic [7:0] high, input logic [7:0] low);
		logic [16:0] r;
		r = {1'b0, high, low};
		case (mode)
			timer_pkg::MODE_PRESCALED13: begin
				// upper three low-byte bits hold their value
				if (low[4:0] == timer_pkg::PRESCALE_LAST) begin
					r[4:0] = 5'h00; // [RULE13]
					r[15:8] = high + 8'h01;
					r[16] = (high == timer_pkg::BYTE_LAST);
				end else begin
					r[4:0] = low[4:0] + 5'h01;
				end
			end
			timer_pkg::MODE_FULL16: begin
				r = {1'b0, high, low} + 17'h00001; // [RULE14]
			end
			timer_pkg::MODE_AUTO_RELOAD8: begin
				if (low == timer_pkg::BYTE_LAST) begin
					r[7:0] = high; // [RULE17]
					r[16] = 1'b1;
				end else begin
					r[7:0] = low + 8'h01;
				end
			end
			default: begin
				// split mode: low byte alone as an 8-bit counter
				r[7:0] = low + 8'h01;
				r[16] = (low == timer_pkg::BYTE_LAST);
			end
		endcase
		return r;
	endfunction

	// run condition: gate bit adds the interrupt pin level to the run bit
	function automatic logic enabled(input logic run, input logic gate, input logic pin);
		return run & (~gate | pin);
	endfunction

	always_comb begin
		timer_pkg::op_mode_t mode0;
		timer_pkg::op_mode_t mode1;
		logic en0;
		logic en1;
		logic inc0;
		logic inc1;
		logic inc_split_high;
		logic [16:0] r0;
		logic [16:0] r1;
		logic [16:0] rh;
		mode0 = timer_pkg::op_mode_t'({s_reg.mode_ctrl[timer_pkg::CH0_MODE_HI_BIT],
			s_reg.mode_ctrl[timer_pkg::CH0_MODE_LO_BIT]}); // [RULE11]
		mode1 = timer_pkg::op_mode_t'({s_reg.mode_ctrl[timer_pkg::CH1_MODE_HI_BIT],
			s_reg.mode_ctrl[timer_pkg::CH1_MODE_LO_BIT]}); // [RULE10]
		en0 = enabled(chan0_run, s_reg.mode_ctrl[timer_pkg::CH0_GATE_BIT],
			lk.gate_level[0]); // [RULE9]
		en1 = enabled(chan1_run, s_reg.mode_ctrl[timer_pkg::CH1_GATE_BIT],
			lk.gate_level[1]); // [RULE9]
		// increment source per channel: machine tick or detected falling edge
		inc0 = en0 & (s_reg.mode_ctrl[timer_pkg::CH0_FSEL_BIT] ?
			lk.count_fall[0] : lk.tick); // [RULE8] [RULE1]
		// channel 1 holds still in mode 3
		inc1 = en1 & (mode1 != timer_pkg::MODE_SPLIT8) &
			(s_reg.mode_ctrl[timer_pkg::CH1_FSEL_BIT] ?
			lk.count_fall[1] : lk.tick); // [RULE8] [RULE12] [RULE17]
		// split channel 0 high byte times machine cycles under channel 1's run bit
		inc_split_high = (mode0 == timer_pkg::MODE_SPLIT8) & chan1_run & lk.tick; // [RULE17]
		r0 = step(mode0, s_reg.high0, s_reg.low0);
		r1 = step(mode1, s_reg.high1, s_reg.low1);
		rh = step(timer_pkg::MODE_SPLIT8, 8'h00, s_reg.high0);

		s_next = s_reg;
		// clears first so that a same-cycle rollover still leaves the flag set
		s_next.ovf = s_reg.ovf & ~overflow_clear;

		// channel 0 counting; edge pulse lands one clk after the sampling tick
		if (inc0) begin
			s_next.low0 = r0[7:0]; // [RULE5] [RULE2]
			if (mode0 != timer_pkg::MODE_SPLIT8) begin
				s_next.high0 = r0[15:8];
			end
			if (r0[16]) begin
				s_next.ovf[0] = 1'b1; // [RULE16]
			end
		end
		if (inc_split_high) begin
			s_next.high0 = rh[7:0];
			if (rh[16]) begin
				s_next.ovf[1] = 1'b1; // [RULE16]
			end
		end

		// channel 1 counting
		if (inc1) begin
			s_next.low1 = r1[7:0]; // [RULE5]
			s_next.high1 = r1[15:8];
			if (r1[16]) begin
				s_next.ovf[1] = 1'b1; // [RULE16]
			end
		end

		// core writes are whole bytes and override a same-cycle count
		if (reg_wr) begin
			case (reg_addr)
				timer_pkg::MODE_CTRL_ADDR: s_next.mode_ctrl = reg_wdata; // [RULE15]
				timer_pkg::CH0_LOW_ADDR: s_next.low0 = reg_wdata;
				timer_pkg::CH0_HIGH_ADDR: s_next.high0 = reg_wdata;
				timer_pkg::CH1_LOW_ADDR: s_next.low1 = reg_wdata;
				timer_pkg::CH1_HIGH_ADDR: s_next.high1 = reg_wdata;
				default: begin
				end
			endcase
		end

		// read data is registered; unmapped addresses read zero
		if (reg_rd) begin
			case (reg_addr)
				timer_pkg::MODE_CTRL_ADDR: s_next.rdata = s_reg.mode_ctrl;
				timer_pkg::CH0_LOW_ADDR: s_next.rdata = s_reg.low0;
				timer_pkg::CH0_HIGH_ADDR: s_next.rdata = s_reg.high0;
				timer_pkg::CH1_LOW_ADDR: s_next.rdata = s_reg.low1;
				timer_pkg::CH1_HIGH_ADDR: s_next.rdata = s_reg.high1;
				timer_pkg::FLAG_ADDR: s_next.rdata = {6'h00, s_reg.ovf};
				default: s_next.rdata = 8'h00;
			endcase
		end

		if (srst) begin
			s_next.mode_ctrl = timer_pkg::MODE_CTRL_RESET; // [RULE15]
			s_next.low0 = timer_pkg::COUNT_RESET;
			s_next.high0 = timer_pkg::COUNT_RESET;
			s_next.low1 = timer_pkg::COUNT_RESET;
			s_next.high1 = timer_pkg::COUNT_RESET;
			s_next.ovf = 2'h0;
			s_next.rdata = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign reg_rdata = s_reg.rdata;
	assign overflow_flag = s_reg.ovf;
endmodule
`default_nettype wire

//--- verilog/timer_pkg.sv
// constants, field layout and mode encoding shared by the dual timer/event counter
// Behaviour
// [RULE1] two independent 16-bit channels, each an interval timer or event counter
// [RULE2] timer function counts one per machine cycle of six oscillator periods
// [RULE3] counter function samples its count pin every machine cycle, counts falling edges
// [RULE4] count only when one sample is high and the next sample low
// [RULE5] incremented value shows in the machine cycle after the detecting one; the code shows it two clks after the sampling tick, in the same machine cycle
// [RULE6] one edge needs two machine cycles, so counting tops at one twelfth clock
// [RULE7] the count source holds each level at least one full machine cycle
// [RULE8] function-select bit picks machine clock or count pin; bits 6 and 2
// [RULE9] gate bit set: run bit and interrupt pin high both needed; bits 7 and 3
// [RULE10] channel 1 mode field sits in bits 5 and 4, upper bit 5
// [RULE11] channel 0 mode field sits in bits 1 and 0, upper bit 1
// [RULE12] four modes per channel; modes 0 to 2 alike, mode 3 differs per channel
// [RULE13] mode 0 makes low byte a 5-bit prescaler under high byte, 13 bits
// [RULE14] mode 1 cascades both bytes into a plain 16-bit counter
// [RULE15] mode register resets to zero and is written only as a whole byte
// [RULE16] rollover of a running channel sets its sticky overflow flag
// [RULE17] mode 2 reloads low byte from high; mode 3 splits channel 0, stops channel 1
`default_nettype none
package timer_pkg;
	// processor-core register addresses
	localparam logic [7:0] MODE_CTRL_ADDR = 8'h89;
	localparam logic [7:0] CH0_LOW_ADDR = 8'ha1;
	localparam logic [7:0] CH0_HIGH_ADDR = 8'ha2;
	localparam logic [7:0] CH1_LOW_ADDR = 8'ha3;
	localparam logic [7:0] CH1_HIGH_ADDR = 8'ha4;
	localparam logic [7:0] FLAG_ADDR = 8'ha5;
	// reset values
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	// mode register field positions
	localparam int CH1_GATE_BIT = 7;
	localparam int CH1_FSEL_BIT = 6;
	localparam int CH1_MODE_HI_BIT = 5;
	localparam int CH1_MODE_LO_BIT = 4;
	localparam int CH0_GATE_BIT = 3;
	localparam int CH0_FSEL_BIT = 2;
	localparam int CH0_MODE_HI_BIT = 1;
	localparam int CH0_MODE_LO_BIT = 0;
	// timing: oscillator periods (clk cycles) per machine cycle
	localparam int OSC_PER_MACHINE_CYCLE = 6;
	localparam int CHANNELS = 2;
	// prescaler of mode 0
	localparam int PRESCALE_BITS = 5;
	localparam logic [4:0] PRESCALE_LAST = 5'h1f;
	localparam logic [7:0] BYTE_LAST = 8'hff;
	// operating modes in field order 00, 01, 10, 11
	typedef enum logic [1:0] {
		MODE_PRESCALED13,
		MODE_FULL16,
		MODE_AUTO_RELOAD8,
		MODE_SPLIT8
	} op_mode_t;
endpackage
`default_nettype wire

//--- verilog/timer_link_if.sv
// carrier between machine cycle generator, pin sampler and channel core
`default_nettype none
interface timer_link_if #(
	parameter int CHANNELS = 2
);
	logic tick;
	logic [CHANNELS-1:0] count_fall;
	logic [CHANNELS-1:0] gate_level;
	modport gen (output tick);
	modport samp (input tick, output count_fall, output gate_level);
	modport core (input tick, input count_fall, input gate_level);
endinterface
`default_nettype wire

//--- verilog/machine_cycle_gen.sv
// machine cycle tick: one clk pulse every OSC_PER_MC oscillator periods
`default_nettype none
module machine_cycle_gen #(
	parameter int OSC_PER_MC = timer_pkg::OSC_PER_MACHINE_CYCLE
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// tick out
	timer_link_if.gen lk
);
	localparam logic [7:0] LAST = 8'(OSC_PER_MC - 1);

	if (OSC_PER_MC < 1 || OSC_PER_MC > 256) begin : g_chk
		$error("machine cycle length out of range");
	end

	typedef struct packed {
		logic [7:0] phase;
		logic tick;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// free-running divider; tick is high during phase 0, the first oscillator period of each machine cycle
	always_comb begin
		s_next = s_reg;
		s_next.tick = 1'b0;
		if (s_reg.phase == LAST) begin
			s_next.phase = 8'h00;
			s_next.tick = 1'b1; // [RULE2]
		end else begin
			s_next.phase = s_reg.phase + 8'h01;
		end
		if (srst) begin
			s_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign lk.tick = s_reg.tick;
endmodule
`default_nettype wire

//--- verilog/count_sampler.sv
// pin synchronisers, machine-cycle sampling and falling-edge detection of count pins
`default_nettype none
module count_sampler #(
	parameter int CHANNELS = timer_pkg::CHANNELS
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// asynchronous pins
	input wire logic [CHANNELS-1:0] count_pins,
	input wire logic [CHANNELS-1:0] gate_pins,
	// results toward the core
	timer_link_if.samp lk
);
	if (CHANNELS < 1) begin : g_chk
		$error("at least one channel needed");
	end

	typedef struct packed {
		logic [CHANNELS-1:0] cnt_meta;
		logic [CHANNELS-1:0] cnt_sync;
		logic [CHANNELS-1:0] gate_meta;
		logic [CHANNELS-1:0] gate_sync;
		logic [CHANNELS-1:0] sample;
		logic [CHANNELS-1:0] fall;
	} state_t;

	state_t s_reg;
	state_t s_next;

	// the first flops feed only the second; sampling looks at the settled copy
	always_comb begin
		s_next = s_reg;
		s_next.cnt_meta = count_pins;
		s_next.cnt_sync = s_reg.cnt_meta;
		s_next.gate_meta = gate_pins;
		s_next.gate_sync = s_reg.gate_meta;
		s_next.fall = '0;
		if (lk.tick) begin
			s_next.sample = s_reg.cnt_sync; // [RULE3]
			// high last machine cycle, low now; pulses can slip if shorter than a cycle
			s_next.fall = s_reg.sample & ~s_reg.cnt_sync; // [RULE4] [RULE6] [RULE7]
		end
		if (srst) begin
			s_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign lk.count_fall = s_reg.fall;
	assign lk.gate_level = s_reg.gate_sync;
endmodule
`default_nettype wire

//--- test/timer_checker.sv
// port-level assertion checker for the dual timer/event counter
`default_nettype none
module timer_checker (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// run bit and flags
	input wire logic chan0_run,
	input wire logic [1:0] overflow_clear,
	input wire logic [1:0] overflow_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mode_reg;
	logic mapped;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// shadow of the mode byte, rebuilt from whole-byte writes only
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_reg <= 8'h00;
		end else if (reg_wr && reg_addr == timer_pkg::MODE_CTRL_ADDR) begin
			mode_reg <= reg_wdata;
		end
	end
	// decoded addresses: mode byte, four count bytes, flags
	assign mapped = reg_addr inside {8'h89, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5};
	sequence s_wr_mode;
		reg_wr && reg_addr == timer_pkg::MODE_CTRL_ADDR;
	endsequence
	sequence s_rd_mode;
		reg_rd && reg_addr == timer_pkg::MODE_CTRL_ADDR;
	endsequence
	AST_RST_CLEAR: assert property (disable iff (1'b0) srst |=>
		reg_rdata == 8'h00 && overflow_flag == 2'b00) else $error("outputs not cleared by reset");
	AST_MODE_RD: assert property (s_rd_mode |=> reg_rdata == $past(mode_reg))
		else $error("mode byte read differs from written value");
	AST_MODE_WR_RD: assert property (s_wr_mode ##1 !reg_wr ##1 s_rd_mode |=>
		reg_rdata == $past(reg_wdata, 3)) else $error("mode write then read mismatch");
	AST_UNMAPPED: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	AST_FLAG0_STICKY: assert property (overflow_flag[0] && !overflow_clear[0] |=>
		overflow_flag[0]) else $error("flag 0 dropped without clear");
	AST_FLAG1_STICKY: assert property (overflow_flag[1] && !overflow_clear[1] |=>
		overflow_flag[1]) else $error("flag 1 dropped without clear");
	AST_FLAG_RD: assert property (reg_rd && reg_addr == timer_pkg::FLAG_ADDR |=>
		reg_rdata == {6'h00, $past(overflow_flag)}) else $error("flag read mismatch");
	AST_FLAG0_RUN: assert property ($rose(overflow_flag[0]) |-> $past(chan0_run) ||
		$past(chan0_run, 2) || $past(chan0_run, 3)) else $error("flag 0 set while stopped");
endmodule
bind dual_timer_event_counter timer_checker i_chk (.clk(clk), .srst(srst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .chan0_run(chan0_run), .overflow_clear(overflow_clear),
	.overflow_flag(overflow_flag));
`default_nettype wire

//--- test/count_source.sv
// behavioural model of the external count and gate pins
`default_nettype none
module count_source (
	// clock
	input wire logic clk,
	// pins toward the device
	output logic count_a,
	output logic count_b,
	output logic gate_a,
	output logic gate_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// count pins idle high so only commanded falls can be counted
	initial begin
		count_a = 1'b1;
		count_b = 1'b1;
		gate_a = 1'b0;
		gate_b = 1'b0;
	end
	// each level held one full machine cycle: the fastest legal source
	task automatic falls(input int ch, input int n);
		repeat (n) begin
			repeat (6) @(posedge clk);
			if (ch == 0) begin
				count_a <= 1'b0;
			end else begin
				count_b <= 1'b0;
			end
			repeat (6) @(posedge clk);
			count_a <= 1'b1;
			count_b <= 1'b1;
		end
	endtask
	// gate pin levels
	task automatic set_gates(input logic ga, input logic gb);
		@(posedge clk);
		gate_a <= ga;
		gate_b <= gb;
	endtask
endmodule
`default_nettype wire

//--- test/dual_timer_event_counter_test.sv
// self-checking bench for the dual timer/event counter
`default_nettype none
module dual_timer_event_counter_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, reg_wr, reg_rd, chan0_run, chan1_run;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, a, b;
	logic [1:0] overflow_clear, overflow_flag;
	wire logic count_input_a, count_input_b, ext_irq_pin_a, ext_irq_pin_b;
	int failures, num_checks;
	dual_timer_event_counter i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chan0_run(chan0_run), .chan1_run(chan1_run), .count_input_a(count_input_a),
		.count_input_b(count_input_b), .ext_irq_pin_a(ext_irq_pin_a),
		.ext_irq_pin_b(ext_irq_pin_b), .overflow_clear(overflow_clear),
		.overflow_flag(overflow_flag));
	count_source i_src (.clk(clk), .count_a(count_input_a), .count_b(count_input_b),
		.gate_a(ext_irq_pin_a), .gate_b(ext_irq_pin_b));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data is taken one edge after the strobe edge, where it stands
	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task automatic rdchk(input string name, input logic [7:0] ad, input logic [7:0] exp);
		rd(ad, a);
		check(name, exp, a);
	endtask
	// growth of a count byte over exactly 60 clocks, phase-independent
	task automatic span(input logic [7:0] ad, output logic [7:0] d);
		rd(ad, a);
		repeat (57) @(posedge clk);
		rd(ad, b);
		d = b - a;
	endtask
	task automatic clr;
		@(posedge clk);
		overflow_clear <= 2'b11;
		@(posedge clk);
		overflow_clear <= 2'b00;
	endtask
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			rdchk("reset value", 8'h89 + 8'(i == 0 ? 0 : i + 23), 8'h00);
		end
		rdchk("unmapped", 8'h90, 8'h00);
		wr(timer_pkg::FLAG_ADDR, 8'hff);
		rdchk("flag read only", timer_pkg::FLAG_ADDR, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(timer_pkg::MODE_CTRL_ADDR, 8'h01 << i);
			rdchk("mode bit", timer_pkg::MODE_CTRL_ADDR, 8'h01 << i);
		end
		$display("test regs done");
	endtask
	task automatic t_timer;
		wr(timer_pkg::MODE_CTRL_ADDR, 8'h01);
		@(posedge clk);
		chan0_run <= 1'b1;
		span(timer_pkg::CH0_LOW_ADDR, b);
		check("timer rate", 8'd10, b);
		wr(timer_pkg::MODE_CTRL_ADDR, 8'h09);
		span(timer_pkg::CH0_LOW_ADDR, b);
		check("gated off", 8'd0, b);
		i_src.set_gates(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		span(timer_pkg::CH0_LOW_ADDR, b);
		check("gated on", 8'd10, b);
		chan0_run <= 1'b0;
		$display("test timer done");
	endtask
	// count from 0xfffe; only the prescaled mode keeps low bits 7..5
	task automatic t_wrap(input logic [7:0] mode, input logic [7:0] top);
		wr(timer_pkg::MODE_CTRL_ADDR, mode);
		wr(timer_pkg::CH0_LOW_ADDR, 8'hfe);
		wr(timer_pkg::CH0_HIGH_ADDR, 8'hff);
		clr;
		chan0_run <= 1'b1;
		repeat (30) @(posedge clk);
		chan0_run <= 1'b0;
		rdchk("high wrap", timer_pkg::CH0_HIGH_ADDR, 8'h00);
		rd(timer_pkg::CH0_LOW_ADDR, a);
		check("low top bits", top, a & 8'he0);
		rdchk("flag set", timer_pkg::FLAG_ADDR, 8'h01);
		check("flag pin set", 8'h01, {6'h00, overflow_flag});
		clr;
		rdchk("flag clear", timer_pkg::FLAG_ADDR, 8'h00);
		check("flag pin clear", 8'h00, {6'h00, overflow_flag});
		$display("test wrap done");
	endtask
	task automatic t_counter;
		wr(timer_pkg::MODE_CTRL_ADDR, 8'h50);
		wr(timer_pkg::CH1_LOW_ADDR, 8'h00);
		chan1_run <= 1'b1;
		i_src.falls(1, 5);
		repeat (18) @(posedge clk);
		rdchk("events", timer_pkg::CH1_LOW_ADDR, 8'h05);
		repeat (60) @(posedge clk);
		rdchk("no events", timer_pkg::CH1_LOW_ADDR, 8'h05);
		chan1_run <= 1'b0;
		$display("test counter done");
	endtask
	task automatic t_modes;
		wr(timer_pkg::MODE_CTRL_ADDR, 8'h32);
		wr(timer_pkg::CH0_LOW_ADDR, 8'hfe);
		wr(timer_pkg::CH0_HIGH_ADDR, 8'hfe);
		wr(timer_pkg::CH1_LOW_ADDR, 8'h44);
		chan0_run <= 1'b1;
		chan1_run <= 1'b1;
		repeat (30) @(posedge clk);
		chan0_run <= 1'b0;
		chan1_run <= 1'b0;
		rdchk("reload high", timer_pkg::CH0_HIGH_ADDR, 8'hfe);
		rd(timer_pkg::CH0_LOW_ADDR, a);
		check("reload low", 8'hfe, a & 8'hfe);
		rdchk("split held", timer_pkg::CH1_LOW_ADDR, 8'h44);
		rdchk("reload flag", timer_pkg::FLAG_ADDR, 8'h01);
		// split channel 0: low byte under its own run bit, high byte under channel 1's
		wr(timer_pkg::MODE_CTRL_ADDR, 8'h03);
		wr(timer_pkg::CH0_LOW_ADDR, 8'h00);
		wr(timer_pkg::CH0_HIGH_ADDR, 8'h00);
		chan0_run <= 1'b1;
		chan1_run <= 1'b1;
		repeat (30) @(posedge clk);
		chan0_run <= 1'b0;
		chan1_run <= 1'b0;
		rdchk("split low", timer_pkg::CH0_LOW_ADDR, 8'h05);
		rdchk("split high", timer_pkg::CH0_HIGH_ADDR, 8'h05);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rdchk("mode after reset", timer_pkg::MODE_CTRL_ADDR, 8'h00);
		rdchk("flag after reset", timer_pkg::FLAG_ADDR, 8'h00);
		$display("test modes done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		{srst, reg_wr, reg_rd, chan0_run, chan1_run} = 5'b10000;
		{reg_addr, reg_wdata, overflow_clear} = '0;
		failures = 0;
		num_checks = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_regs;
		t_timer;
		t_wrap(8'h00, 8'he0);
		t_wrap(8'h01, 8'h00);
		t_counter;
		t_modes;
		close_out;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		close_out;
	end
endmodule
`default_nettype wire
